// *** hw/ppo_port.sv ***
// Summary of operation
// - deep sleep clamps each digital input low
// - clamp skipped where pin interrupt enabled
// - clamp release on high pin sets flag under rising or any-change sense
// - pull-ups off while reset is held
// - plain pull-up only for input, level one, enabled
// - pull-up override value alone decides pull-up
// - driver from direction bit or override
// - driver override value forces driver on/off
// - driven level from override or level bit
// - level override value sets the pad level
// - toggle override inverts the level bit
// - input enable from override or sleep state
// - input enable override works regardless of sleep
// - peripherals get unsynchronised input tap, sync themselves
// - sleep, pull-up off shared; overrides per pin
// - direction one is output, zero input
// - global pull-up off kills every pull-up not under peripheral override
`timescale 1ns/1ps
`default_nettype none
`include "ppo_regs.svh"

module ppo_port #(
  parameter int N = 8
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // sleep controller, same clock
  input  wire logic          sleep_i,
  // peripheral overrides, one bit per pin
  input  wire logic [N-1:0]  pullup_ovr_en_i,
  input  wire logic [N-1:0]  pullup_ovr_val_i,
  input  wire logic [N-1:0]  drive_ovr_en_i,
  input  wire logic [N-1:0]  drive_ovr_val_i,
  input  wire logic [N-1:0]  level_ovr_en_i,
  input  wire logic [N-1:0]  level_ovr_val_i,
  input  wire logic [N-1:0]  invert_ovr_en_i,
  input  wire logic [N-1:0]  input_en_ovr_en_i,
  input  wire logic [N-1:0]  input_en_ovr_val_i,
  output logic      [N-1:0]  raw_pad_input_tap_o,
  // pad side
  input  wire logic [N-1:0]  pad_i,
  output logic      [N-1:0]  pad_o,
  output logic      [N-1:0]  pad_oe_o,
  output logic      [N-1:0]  pullup_o,
  // interrupt
  output logic               irq_o
);

  logic [N-1:0]     direction_bit_q;
  logic [N-1:0]     output_level_bit_q;
  logic             global_pullup_off_q;
  logic [N-1:0]     stat_q;
  logic [N-1:0]     mask_q;
  logic [2*N-1:0]   sense_q;
  logic [N-1:0]     input_en_q;
  logic [N-1:0]     sync1_q;
  logic [N-1:0]     pad_sample_bit_q;
  logic [N-1:0]     prev_q;
  logic [N-1:0]     edge_set;
  logic [N-1:0]     pullup_d;
  logic [N-1:0]     drive_en_d;
  logic [N-1:0]     level_d;
  logic [N-1:0]     input_en_d;
  logic [31:0]      wmask;
  logic [31:0]      wbits;
  logic             req;
  logic             wr;
  logic [N-1:0]     toggle;
  logic [N-1:0]     out_d;

  // bus request decode; one wait state, ack is registered
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr    = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wbits = wb_dat_i & wmask;

  // wishbone answer: unmapped offsets ack and read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `PPO_RST_WORD;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= `PPO_RST_WORD;
      if (req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          `PPO_OFS_DIR:   wb_dat_o[N-1:0]   <= direction_bit_q;
          `PPO_OFS_OUT:   wb_dat_o[N-1:0]   <= output_level_bit_q;
          `PPO_OFS_PIN:   wb_dat_o[N-1:0]   <= pad_sample_bit_q;
          `PPO_OFS_CTRL:  wb_dat_o[`PPO_CTRL_PUOFF] <= global_pullup_off_q;
          `PPO_OFS_STAT:  wb_dat_o[N-1:0]   <= stat_q;
          `PPO_OFS_MASK:  wb_dat_o[N-1:0]   <= mask_q;
          `PPO_OFS_SENSE: wb_dat_o[2*N-1:0] <= sense_q;
          default:        wb_dat_o          <= `PPO_RST_WORD;
        endcase
      end
    end
  end

  // direction register; a one makes the pin an output
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      direction_bit_q <= `PPO_RST_PINS;
    else if (wr && wb_adr_i == `PPO_OFS_DIR)
      direction_bit_q <= (direction_bit_q & ~wmask[N-1:0]) | wbits[N-1:0];
  end

  // level bit: bus write first, then toggles from a pin-sample write or a peripheral
  assign toggle = invert_ovr_en_i | ((wr && wb_adr_i == `PPO_OFS_PIN) ? wbits[N-1:0] : '0);
  always_comb
  begin
    out_d = output_level_bit_q;
    if (wr && wb_adr_i == `PPO_OFS_OUT)
      out_d = (output_level_bit_q & ~wmask[N-1:0]) | wbits[N-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      output_level_bit_q <= `PPO_RST_PINS;
    else
      output_level_bit_q <= out_d ^ toggle;
  end

  // shared control, interrupt enable and sense registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      global_pullup_off_q <= 1'b0;
      mask_q              <= `PPO_RST_PINS;
      sense_q             <= `PPO_RST_SENSE;
    end
    else if (wr)
    begin
      if (wb_adr_i == `PPO_OFS_CTRL && wb_sel_i[0])
        global_pullup_off_q <= wb_dat_i[`PPO_CTRL_PUOFF];
      if (wb_adr_i == `PPO_OFS_MASK)
        mask_q <= (mask_q & ~wmask[N-1:0]) | wbits[N-1:0];
      if (wb_adr_i == `PPO_OFS_SENSE)
        sense_q <= (sense_q & ~wmask[2*N-1:0]) | wbits[2*N-1:0];
    end
  end

  // clamp sits before the synchroniser, as the input buffer gate does
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q          <= `PPO_RST_PINS;
      pad_sample_bit_q <= `PPO_RST_PINS;
      prev_q           <= `PPO_RST_PINS;
    end
    else
    begin
      sync1_q          <= pad_i & input_en_q;
      pad_sample_bit_q <= sync1_q;
      prev_q           <= pad_sample_bit_q;
    end
  end

  // unsynchronised tap; taking it through a flop here would add a half-built sync
  assign raw_pad_input_tap_o = pad_i & input_en_q;

  // flags see the clamped level, so clamp release on a high pin reads as an edge
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      ppo_pkg::ppo_sense_e sense;
      logic                hit;
      assign sense = ppo_pkg::ppo_sense_e'(sense_q[`PPO_SENSE_W*g +: `PPO_SENSE_W]);

      // per-pin detector kept local so the shared vector has one driver per bit
      always_comb
      begin
        unique case (sense)
          ppo_pkg::PPO_SENSE_LOW:  hit = !pad_sample_bit_q[g];
          ppo_pkg::PPO_SENSE_ANY:  hit = pad_sample_bit_q[g] ^ prev_q[g];
          ppo_pkg::PPO_SENSE_FALL: hit = prev_q[g] && !pad_sample_bit_q[g];
          ppo_pkg::PPO_SENSE_RISE: hit = !prev_q[g] && pad_sample_bit_q[g];
        endcase
      end
      assign edge_set[g] = hit;

      ppo_pin_cell u_cell (
        .direction_bit_i     (direction_bit_q[g]),
        .output_level_bit_i  (output_level_bit_q[g]),
        .global_pullup_off_i (global_pullup_off_q),
        .sleep_clamp_i       (sleep_i && !mask_q[g]),
        .pullup_ovr_en_i     (pullup_ovr_en_i[g]),
        .pullup_ovr_val_i    (pullup_ovr_val_i[g]),
        .drive_ovr_en_i      (drive_ovr_en_i[g]),
        .drive_ovr_val_i     (drive_ovr_val_i[g]),
        .level_ovr_en_i      (level_ovr_en_i[g]),
        .level_ovr_val_i     (level_ovr_val_i[g]),
        .input_en_ovr_en_i   (input_en_ovr_en_i[g]),
        .input_en_ovr_val_i  (input_en_ovr_val_i[g]),
        .pullup_d_o          (pullup_d[g]),
        .drive_en_d_o        (drive_en_d[g]),
        .level_d_o           (level_d[g]),
        .input_en_d_o        (input_en_d[g])
      );

      property p_sleep_clamp;
        @(posedge clk_i) disable iff (rst_i)
        (sleep_i && !mask_q[g] && !input_en_ovr_en_i[g]) |=> !input_en_q[g] ##2 !pad_sample_bit_q[g];
      endproperty
      a_sleep_clamp: assert property (p_sleep_clamp)
        else $error("input not clamped in sleep");

      property p_int_pin_open;
        @(posedge clk_i) disable iff (rst_i)
        (mask_q[g] && !input_en_ovr_en_i[g]) |=> input_en_q[g];
      endproperty
      a_int_pin_open: assert property (p_int_pin_open)
        else $error("interrupt pin clamped");

      property p_plain_pullup;
        @(posedge clk_i) disable iff (rst_i)
        !pullup_ovr_en_i[g] |=> pullup_o[g] ==
          (!$past(direction_bit_q[g]) && $past(output_level_bit_q[g]) && !$past(global_pullup_off_q));
      endproperty
      a_plain_pullup: assert property (p_plain_pullup)
        else $error("plain pull-up wrong");

      property p_pullup_ovr;
        @(posedge clk_i) disable iff (rst_i)
        pullup_ovr_en_i[g] |=> pullup_o[g] == $past(pullup_ovr_val_i[g]);
      endproperty
      a_pullup_ovr: assert property (p_pullup_ovr)
        else $error("pull-up override ignored");

      property p_drive;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> pad_oe_o[g] == ($past(drive_ovr_en_i[g]) ? $past(drive_ovr_val_i[g])
                                                          : $past(direction_bit_q[g]));
      endproperty
      a_drive: assert property (p_drive)
        else $error("driver enable wrong");

      property p_level_ovr;
        @(posedge clk_i) disable iff (rst_i)
        level_ovr_en_i[g] |=> pad_o[g] == $past(level_ovr_val_i[g]);
      endproperty
      a_level_ovr: assert property (p_level_ovr)
        else $error("level override ignored");

      property p_toggle;
        @(posedge clk_i) disable iff (rst_i)
        (invert_ovr_en_i[g] && !wr) |=> output_level_bit_q[g] != $past(output_level_bit_q[g]);
      endproperty
      a_toggle: assert property (p_toggle)
        else $error("toggle did not invert");

      property p_ie_ovr;
        @(posedge clk_i) disable iff (rst_i)
        input_en_ovr_en_i[g] |=> input_en_q[g] == $past(input_en_ovr_val_i[g]);
      endproperty
      a_ie_ovr: assert property (p_ie_ovr)
        else $error("input enable override ignored");

      property p_rise_flag;
        @(posedge clk_i) disable iff (rst_i)
        (sense == ppo_pkg::PPO_SENSE_RISE && !prev_q[g] && pad_sample_bit_q[g]) |=> stat_q[g];
      endproperty
      a_rise_flag: assert property (p_rise_flag)
        else $error("rising edge flag lost");
    end
  endgenerate

  // pad controls all leave through flops; pull-ups cleared by reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pullup_o   <= `PPO_RST_PINS;
      pad_oe_o   <= `PPO_RST_PINS;
      pad_o      <= `PPO_RST_PINS;
      input_en_q <= `PPO_RST_PINS;
    end
    else
    begin
      pullup_o   <= pullup_d;
      pad_oe_o   <= drive_en_d;
      pad_o      <= level_d;
      input_en_q <= input_en_d;
    end
  end

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_q <= `PPO_RST_PINS;
    else if (wr && wb_adr_i == `PPO_OFS_STAT)
      stat_q <= (stat_q & ~wbits[N-1:0]) | edge_set;
    else
      stat_q <= stat_q | edge_set;
  end

  // one level interrupt for all enabled flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(stat_q & mask_q);
  end

  property p_reset_pullup;
    @(posedge clk_i)
    rst_i |=> pullup_o == `PPO_RST_PINS;
  endproperty
  a_reset_pullup: assert property (p_reset_pullup)
    else $error("pull-up on during reset");

  property p_plain_port;
    @(posedge clk_i) disable iff (rst_i)
    (pullup_ovr_en_i == '0 && drive_ovr_en_i == '0 && level_ovr_en_i == '0)
      |=> (pad_oe_o == $past(direction_bit_q)) && (pad_o == $past(output_level_bit_q));
  endproperty
  a_plain_port: assert property (p_plain_port)
    else $error("plain port path wrong");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not a one-cycle answer");

endmodule : ppo_port

`default_nettype wire

// *** hw/ppo_regs.svh ***
`ifndef PPO_REGS_SVH
`define PPO_REGS_SVH

// register byte offsets on the wishbone port, one aligned word each
`define PPO_OFS_DIR    8'h00
`define PPO_OFS_OUT    8'h04
`define PPO_OFS_PIN    8'h08
`define PPO_OFS_CTRL   8'h0c
`define PPO_OFS_STAT   8'h10
`define PPO_OFS_MASK   8'h14
`define PPO_OFS_SENSE  8'h18

// field positions and widths
`define PPO_CTRL_PUOFF 0
`define PPO_SENSE_W    2

// reset values
`define PPO_RST_PINS   8'h00
`define PPO_RST_SENSE  16'h0000
`define PPO_RST_WORD   32'h0000_0000

`endif

// *** hw/ppo_pkg.sv ***
package ppo_pkg;

  // edge or level that raises a pin's interrupt flag
  typedef enum logic [1:0] {
    PPO_SENSE_LOW  = 2'h0,
    PPO_SENSE_ANY  = 2'h1,
    PPO_SENSE_FALL = 2'h2,
    PPO_SENSE_RISE = 2'h3
  } ppo_sense_e;

endpackage : ppo_pkg

// *** hw/ppo_pin_cell.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppo_pin_cell (
  // plain port register bits
  input  wire logic direction_bit_i,
  input  wire logic output_level_bit_i,
  // shared controls
  input  wire logic global_pullup_off_i,
  input  wire logic sleep_clamp_i,
  // peripheral overrides for this pin
  input  wire logic pullup_ovr_en_i,
  input  wire logic pullup_ovr_val_i,
  input  wire logic drive_ovr_en_i,
  input  wire logic drive_ovr_val_i,
  input  wire logic level_ovr_en_i,
  input  wire logic level_ovr_val_i,
  input  wire logic input_en_ovr_en_i,
  input  wire logic input_en_ovr_val_i,
  // next values of the pad controls
  output logic      pullup_d_o,
  output logic      drive_en_d_o,
  output logic      level_d_o,
  output logic      input_en_d_o
);

  // pull-up: plain only for input with level bit set and no global off
  always_comb
  begin
    if (pullup_ovr_en_i)
      pullup_d_o = pullup_ovr_val_i;
    else
      pullup_d_o = ({direction_bit_i, output_level_bit_i, global_pullup_off_i} == 3'h2);
  end

  // output driver enable and driven level
  always_comb
  begin
    drive_en_d_o = drive_ovr_en_i ? drive_ovr_val_i : direction_bit_i;
    level_d_o    = level_ovr_en_i ? level_ovr_val_i : output_level_bit_i;
  end

  // digital input enable: override beats the sleep clamp
  always_comb
  begin
    if (input_en_ovr_en_i)
      input_en_d_o = input_en_ovr_val_i;
    else
      input_en_d_o = !sleep_clamp_i;
  end

endmodule : ppo_pin_cell

`default_nettype wire

// *** tb/ppo_periph_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module ppo_periph_model #(
  parameter int N = 8
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // override request from the bench, index 0..8 as on the port list
  input  wire logic                load_i,
  input  wire logic [8:0][N-1:0]   ovr_i,
  output logic      [8:0][N-1:0]   ovr_o,
  // raw tap from the port and the local synchronised copy
  input  wire logic [N-1:0]        tap_i,
  output logic      [N-1:0]        tap_sync_o
);
  logic [N-1:0] tap_meta_q;

  // each peripheral makes its own per-pin overrides; toggle is a one-clock pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ovr_o <= '0;
    end
    else
    begin
      if (load_i)
      begin
        ovr_o <= ovr_i;
      end
      else
      begin
        ovr_o[6] <= '0;
      end
    end
  end

  // the tap is unsynchronised, so two flops guard against metastability
  always_ff @(posedge clk_i)
  begin
    tap_meta_q <= tap_i;
    tap_sync_o <= tap_meta_q;
  end
endmodule : ppo_periph_model

`default_nettype wire

// *** tb/port_pin_override_logic_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ppo_regs.svh"
`define PPO_CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module port_pin_override_logic_tb;
  localparam int N = 8;
  logic               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_i, load;
  logic [7:0]         wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i, wb_dat_o;
  logic               wb_ack_o, irq_o;
  logic [8:0][N-1:0]  ovr, ov;
  logic [N-1:0]       pad_i, pad_o, pad_oe_o, pullup_o, raw_pad_input_tap_o, tap_sync;
  int                 err_count, checks_done;

  ppo_port #(.N(N)) ppo_port_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .sleep_i, .pullup_ovr_en_i(ov[0]), .pullup_ovr_val_i(ov[1]),
    .drive_ovr_en_i(ov[2]), .drive_ovr_val_i(ov[3]), .level_ovr_en_i(ov[4]),
    .level_ovr_val_i(ov[5]), .invert_ovr_en_i(ov[6]), .input_en_ovr_en_i(ov[7]),
    .input_en_ovr_val_i(ov[8]), .raw_pad_input_tap_o, .pad_i, .pad_o, .pad_oe_o,
    .pullup_o, .irq_o);

  ppo_periph_model #(.N(N)) ppo_periph_model_inst (
    .clk_i, .rst_i, .load_i(load), .ovr_i(ovr), .ovr_o(ov),
    .tap_i(raw_pad_input_tap_o), .tap_sync_o(tap_sync));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // one classic cycle; waits for ack, only the watchdog ends a hang
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  // expected {pullup, drive enable, driven level, input enable}
  function automatic logic [4*N-1:0] exp_pins(logic [N-1:0] dir, out, msk, logic puoff,
                                               logic slp, logic [8:0][N-1:0] o);
    logic [N-1:0] pu, oe, lv, ie;
    pu = (o[0] & o[1]) | (~o[0] & ~dir & out & {N{~puoff}});
    oe = (o[2] & o[3]) | (~o[2] & dir);
    lv = (o[4] & o[5]) | (~o[4] & out);
    ie = (o[7] & o[8]) | (~o[7] & ~({N{slp}} & ~msk));
    return {pu, oe, lv & oe, ie};
  endfunction : exp_pins

  task automatic final_report();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    final_report();
  end

  initial
  begin
    logic [31:0]       d;
    logic [4*N-1:0]    e;
    logic [N-1:0]      dir, out, ie;
    logic              puoff, slp;
    logic [8:0][N-1:0] o;
    logic [7:0]        ofs [6];
    clk_i = 0; rst_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 8'h00;
    wb_sel_i = 4'h0; wb_dat_i = 32'h0; sleep_i = 0; load = 0; ovr = '0; pad_i = '0;
    err_count = 0; checks_done = 0;
    ofs = '{`PPO_OFS_DIR, `PPO_OFS_OUT, `PPO_OFS_CTRL, `PPO_OFS_MASK, `PPO_OFS_SENSE, 8'h1c};
    void'($urandom(84677));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, and an unmapped offset reading zero
    foreach (ofs[k])
    begin
      wb_xfer(1'b0, ofs[k], 32'h0, d);
      `PPO_CHK(d, `PPO_RST_WORD)
    end
    // random configurations; the first few keep every override low
    for (int i = 0; i < 40; i++)
    begin
      dir = N'($urandom);
      out = N'($urandom);
      puoff = 1'($urandom);
      slp = 1'($urandom);
      for (int k = 0; k < 9; k++) o[k] = (i < 4) ? '0 : N'($urandom);
      wb_xfer(1'b1, `PPO_OFS_DIR, {24'h0, dir}, d);
      wb_xfer(1'b1, `PPO_OFS_OUT, {24'h0, out}, d);
      wb_xfer(1'b1, `PPO_OFS_CTRL, {31'h0, puoff}, d);
      ovr <= o;
      pad_i <= N'($urandom);
      sleep_i <= slp;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      out = out ^ o[6];
      repeat (5) @(posedge clk_i);
      e = exp_pins(dir, out, '0, puoff, slp, o);
      ie = e[N-1:0];
      `PPO_CHK(pullup_o, e[4*N-1:3*N])
      `PPO_CHK(pad_oe_o, e[3*N-1:2*N])
      `PPO_CHK(pad_o & e[3*N-1:2*N], e[2*N-1:N])
      `PPO_CHK(raw_pad_input_tap_o, pad_i & ie)
      `PPO_CHK(tap_sync, pad_i & ie)
      `PPO_CHK(irq_o, 1'b0)
      wb_xfer(1'b0, `PPO_OFS_OUT, 32'h0, d);
      `PPO_CHK(d[N-1:0], out)
      wb_xfer(1'b0, `PPO_OFS_PIN, 32'h0, d);
      `PPO_CHK(d[N-1:0], pad_i & ie)
    end
    // pull-ups on, then reset held: they must drop
    ovr <= '0;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
    wb_xfer(1'b1, `PPO_OFS_DIR, 32'h0, d);
    wb_xfer(1'b1, `PPO_OFS_CTRL, 32'h0, d);
    wb_xfer(1'b1, `PPO_OFS_OUT, 32'hff, d);
    repeat (3) @(posedge clk_i);
    `PPO_CHK(pullup_o, 8'hff)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `PPO_CHK(pullup_o, 8'h00)
    rst_i <= 1'b0;
    @(posedge clk_i);
    // register toggle through the sample offset
    wb_xfer(1'b1, `PPO_OFS_PIN, 32'h0f, d);
    wb_xfer(1'b0, `PPO_OFS_OUT, 32'h0, d);
    `PPO_CHK(d[N-1:0], 8'h0f)
    // clamp release on high pins looks like a rising edge
    wb_xfer(1'b1, `PPO_OFS_SENSE, 32'h0000ffff, d);
    pad_i <= '1;
    repeat (6) @(posedge clk_i);
    wb_xfer(1'b1, `PPO_OFS_STAT, 32'hff, d);
    wb_xfer(1'b0, `PPO_OFS_STAT, 32'h0, d);
    `PPO_CHK(d[N-1:0], 8'h00)
    for (int r = 0; r < 2; r++)
    begin
      sleep_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      `PPO_CHK(raw_pad_input_tap_o, (r == 0) ? 8'h00 : 8'h01)
      sleep_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      wb_xfer(1'b0, `PPO_OFS_STAT, 32'h0, d);
      `PPO_CHK(d[N-1:0], (r == 0) ? 8'hff : 8'hfe)
      `PPO_CHK(irq_o, 1'b0)
      if (r == 0)
      begin
        wb_xfer(1'b1, `PPO_OFS_MASK, 32'h01, d);
        repeat (3) @(posedge clk_i);
        `PPO_CHK(irq_o, 1'b1)
        wb_xfer(1'b1, `PPO_OFS_STAT, 32'hff, d);
        repeat (3) @(posedge clk_i);
        `PPO_CHK(irq_o, 1'b0)
      end
    end
    // sleep entry and exit: any-change on pins 0..3, falling on pins 4..7
    wb_xfer(1'b1, `PPO_OFS_SENSE, 32'h0000aa55, d);
    wb_xfer(1'b1, `PPO_OFS_STAT, 32'hff, d);
    sleep_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wb_xfer(1'b0, `PPO_OFS_STAT, 32'h0, d);
    `PPO_CHK(d[N-1:0], 8'hfe)
    wb_xfer(1'b1, `PPO_OFS_STAT, 32'hff, d);
    sleep_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb_xfer(1'b0, `PPO_OFS_STAT, 32'h0, d);
    `PPO_CHK(d[N-1:0], 8'h0e)
    final_report();
  end
endmodule : port_pin_override_logic_tb

`default_nettype wire
